// *** rtl/bsx_defs.svh ***
// bsx_defs.svh: offsets, field positions, reset values and cycle counts
// of the branch / skip / bit-op execution block; included by bare name.
`ifndef BSX_DEFS_SVH
`define BSX_DEFS_SVH

// ==========================================================
// register byte offsets
`define BSX_OFS_CMD     9'h000
`define BSX_OFS_PC      9'h004
`define BSX_OFS_STATUS_FLAG_REGISTER    9'h008
`define BSX_OFS_RD      9'h00C
`define BSX_OFS_STAT    9'h010
// io window: byte 0x100 + 4 * io address
`define BSX_IOWIN_BIT   8

// ==========================================================
// command word fields
`define BSX_CMD_OP      4:0
`define BSX_CMD_SEL     10:8
`define BSX_CMD_IOA     21:16
`define BSX_CMD_TWO     24
`define BSX_CMD_K       31:25

// ==========================================================
// status flag positions
`define BSX_FLG_C       0
`define BSX_FLG_Z       1
`define BSX_FLG_N       2
`define BSX_FLG_V       3
`define BSX_FLG_S       4
`define BSX_FLG_H       5
`define BSX_FLG_T       6
`define BSX_FLG_I       7

// ==========================================================
// reset values and cycle counts
`define BSX_PC_RST      16'h0000
`define BSX_STATUS_FLAG_REGISTER_RST    8'h00
`define BSX_RD_RST      8'h00
`define BSX_CYC_ONE     2'h1
`define BSX_CYC_TWO     2'h2
`define BSX_CYC_THREE   2'h3
`define BSX_RESP_OKAY   2'h0
`define BSX_RESP_SLVERR 2'h2

`endif

// *** rtl/bsx_pkg.sv ***
// bsx_pkg: operation codes, state type and operation class decoders.
// assumes nothing beyond the defs header for field widths.
package bsx_pkg;

	// ==========================================================
	// operations
	typedef enum logic [4:0] {
		SKIP_ON_IO_BIT_LOW, SKIP_ON_IO_BIT_HIGH,
		BRANCH_FLAG_SET_GENERIC, BRANCH_FLAG_CLEAR_GENERIC,
		BRANCH_ON_EQUAL, BRANCH_ON_NOT_EQUAL,
		BRANCH_ON_CARRY_SET, BRANCH_ON_CARRY_CLEAR,
		BRANCH_SAME_OR_HIGHER, BRANCH_ON_LOWER,
		BRANCH_ON_MINUS, BRANCH_ON_PLUS,
		BRANCH_SIGNED_GE, BRANCH_SIGNED_LESS,
		BRANCH_HALF_CARRY_SET, BRANCH_HALF_CARRY_CLEAR,
		BRANCH_TRANSFER_BIT_SET, BRANCH_TRANSFER_BIT_CLEAR,
		BRANCH_ON_OVERFLOW, BRANCH_ON_NO_OVERFLOW,
		BRANCH_IRQ_ENABLED, BRANCH_IRQ_DISABLED,
		SET_IO_REGISTER_BIT, CLEAR_IO_REGISTER_BIT,
		SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL
	} bsx_op_t;

	typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_REST} bsx_fsm_t;

	// ==========================================================
	// whole state of the main module
	typedef struct packed {
		bsx_fsm_t    fsm;
		logic        busy;
		logic        done;
		logic [1:0]  cnt;
		logic [1:0]  ncyc;
		bsx_op_t     op;
		logic [2:0]  sel;
		logic [5:0]  ioa;
		logic        two;
		logic [6:0]  k;
		logic        taken;
		logic        tested;
		logic [7:0]  iowd;
		logic [15:0] pc;
		logic [7:0]  status_flag_register;
		logic [7:0]  rd;
		logic [15:0] start_pc;
		logic [7:0]  start_status_flag_register;
		logic [7:0]  start_rd;
		logic        aw_have;
		logic [8:0]  awaddr;
		logic        awready;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        ar_have;
		logic        ar_wait;
		logic [8:0]  araddr;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} bsx_st_t;

	// ==========================================================
	// operation classes
	function automatic logic is_branch(input bsx_op_t op);
		return op >= BRANCH_FLAG_SET_GENERIC && op <= BRANCH_IRQ_DISABLED;
	endfunction : is_branch

	function automatic logic is_skip(input bsx_op_t op);
		return op == SKIP_ON_IO_BIT_LOW || op == SKIP_ON_IO_BIT_HIGH;
	endfunction : is_skip

	function automatic logic is_bitop(input bsx_op_t op);
		return op == SET_IO_REGISTER_BIT || op == CLEAR_IO_REGISTER_BIT;
	endfunction : is_bitop

endpackage : bsx_pkg

// *** rtl/bsx_io_mem.sv ***
// bsx_io_mem: the io register space, one write/read port, registered read.
// assumes one user per cycle; read data lag the address by one edge.
`timescale 1ns/1ps
module bsx_io_mem #(
	parameter int DEPTH = 64
) (
	// clock
	input  wire logic       clk,
	// port
	input  wire logic       we,
	input  wire logic [5:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	// no reset on the array: io registers hold whatever software left
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

	if (DEPTH < 1 || DEPTH > 64) begin : g_chk
		$error("io depth must be 1 to 64");
	end
endmodule : bsx_io_mem

// *** rtl/bsx_cond.sv ***
// bsx_cond: decides whether a skip or branch is taken.
// assumes the io bit comes from the registered read of the io space.
`timescale 1ns/1ps
`include "bsx_defs.svh"
module bsx_cond (
	// operation
	input  wire bsx_pkg::bsx_op_t op,
	input  wire logic [2:0]       sel,
	// operands
	input  wire logic [7:0]       status_flag_register,
	input  wire logic             io_bit,
	// verdict
	output logic                  cond_true,
	output logic                  tested
);
	int  idx;
	logic want;

	always_comb begin
		idx    = 0;
		want   = 1'b1;
		tested = 1'b0;
		case (op)
			bsx_pkg::SKIP_ON_IO_BIT_LOW:        begin tested = io_bit; want = 1'b0; end
			bsx_pkg::SKIP_ON_IO_BIT_HIGH:       begin tested = io_bit; end
			bsx_pkg::BRANCH_FLAG_SET_GENERIC:   begin idx = int'(sel); end
			bsx_pkg::BRANCH_FLAG_CLEAR_GENERIC: begin idx = int'(sel); want = 1'b0; end
			bsx_pkg::BRANCH_ON_EQUAL:           begin idx = `BSX_FLG_Z; end
			bsx_pkg::BRANCH_ON_NOT_EQUAL:       begin idx = `BSX_FLG_Z; want = 1'b0; end
			bsx_pkg::BRANCH_ON_CARRY_SET,
			bsx_pkg::BRANCH_ON_LOWER:           begin idx = `BSX_FLG_C; end
			bsx_pkg::BRANCH_ON_CARRY_CLEAR,
			bsx_pkg::BRANCH_SAME_OR_HIGHER:     begin idx = `BSX_FLG_C; want = 1'b0; end
			bsx_pkg::BRANCH_ON_MINUS:           begin idx = `BSX_FLG_N; end
			bsx_pkg::BRANCH_ON_PLUS:            begin idx = `BSX_FLG_N; want = 1'b0; end
			bsx_pkg::BRANCH_HALF_CARRY_SET:     begin idx = `BSX_FLG_H; end
			bsx_pkg::BRANCH_HALF_CARRY_CLEAR:   begin idx = `BSX_FLG_H; want = 1'b0; end
			bsx_pkg::BRANCH_TRANSFER_BIT_SET:   begin idx = `BSX_FLG_T; end
			bsx_pkg::BRANCH_TRANSFER_BIT_CLEAR: begin idx = `BSX_FLG_T; want = 1'b0; end
			bsx_pkg::BRANCH_ON_OVERFLOW:        begin idx = `BSX_FLG_V; end
			bsx_pkg::BRANCH_ON_NO_OVERFLOW:     begin idx = `BSX_FLG_V; want = 1'b0; end
			bsx_pkg::BRANCH_IRQ_ENABLED:        begin idx = `BSX_FLG_I; end
			bsx_pkg::BRANCH_IRQ_DISABLED:       begin idx = `BSX_FLG_I; want = 1'b0; end
			default:                            begin want = 1'b0; end
		endcase
		// signed compares test n xor v rather than a single flag
		if (op == bsx_pkg::BRANCH_SIGNED_GE || op == bsx_pkg::BRANCH_SIGNED_LESS) begin
			tested = status_flag_register[`BSX_FLG_N] ^ status_flag_register[`BSX_FLG_V];
			want   = (op == bsx_pkg::BRANCH_SIGNED_LESS);
		end else if (bsx_pkg::is_branch(op)) begin
			tested = status_flag_register[idx[2:0]];
		end
		cond_true = (bsx_pkg::is_branch(op) || bsx_pkg::is_skip(op)) && (tested == want);
	end
endmodule : bsx_cond

// *** rtl/bsx_exec.sv ***
// bsx_exec: executes skips on io bits, flag branches, io bit set/clear and
// logical shifts against a program counter, status flags and one operand
// register, all reached over an axi4-lite slave. assumes a single clock.
// Function
// - skip on io bit low advances pc by 2 or 3; no flag change
// - skip on io bit high advances pc by 2 or 3; no flag change
// - generic set branch tests indexed flag, jumps pc+k+1 when one
// - generic clear branch tests indexed flag, jumps pc+k+1 when zero
// - equal branch jumps on z one, not-equal on z zero
// - carry set and lower jump on c one; clear and same-or-higher on zero
// - minus branch on n one, plus branch on n zero, to pc+k+1
// - signed ge jumps when n xor v is zero, less when one
// - half carry branches jump on h one or h zero, 1 or 2 cycles
// - transfer bit branches jump on t one or zero, flags untouched
// - overflow branches jump on v one or zero, 1 or 2 cycles
// - interrupt branches jump on global enable one or zero
// - set io bit forces selected bit to one in 2 cycles
// - clear io bit forces selected bit to zero in 2 cycles
// - shift left fills bit 0 with zero, updates z c n v, 1 cycle
// - shift right fills bit 7 with zero, updates z c n v, 1 cycle
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "bsx_defs.svh"
module bsx_exec #(
	parameter int IO_DEPTH = 64
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [8:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [8:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// execution status
	output logic             exec_busy,
	output logic             exec_done
);
	// ==========================================================
	// state, memory and condition
	bsx_pkg::bsx_st_t s_ff;
	bsx_pkg::bsx_st_t nxt_s;
	logic             mem_we;
	logic [5:0]       mem_addr;
	logic [7:0]       mem_wdata;
	logic [7:0]       mem_rdata;
	logic             c_true;
	logic             c_tested;

	bsx_io_mem #(.DEPTH(IO_DEPTH)) u_mem (
		.clk  (aclk),
		.we   (mem_we),
		.addr (mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	bsx_cond u_cond (
		.op       (s_ff.op),
		.sel      (s_ff.sel),
		.status_flag_register     (s_ff.status_flag_register),
		.io_bit   (mem_rdata[s_ff.sel]),
		.cond_true(c_true),
		.tested   (c_tested)
	);

	if (IO_DEPTH < 1 || IO_DEPTH > 64) begin : g_chk
		$error("io depth must be 1 to 64");
	end

	// ==========================================================
	// helpers
	function automatic logic is_io(input logic [8:0] a);
		return a[`BSX_IOWIN_BIT] && int'(a[7:2]) < IO_DEPTH;
	endfunction : is_io

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
		input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = w[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [31:0] cmd_view(input bsx_pkg::bsx_st_t s);
		logic [31:0] v;
		v = 32'h0;
		v[`BSX_CMD_OP]  = s.op;
		v[`BSX_CMD_SEL] = s.sel;
		v[`BSX_CMD_IOA] = s.ioa;
		v[`BSX_CMD_TWO] = s.two;
		v[`BSX_CMD_K]   = s.k;
		return v;
	endfunction : cmd_view

	// ==========================================================
	// next state
	always_comb begin
		logic [15:0] pc1;
		logic [15:0] koff;
		logic [7:0]  res;
		logic [7:0]  mask;
		logic [1:0]  ncyc;
		logic [31:0] cm;
		logic [31:0] pw;
		logic        wr_fire;
		logic        mem_used;
		pc1      = s_ff.pc + 16'h0001;
		koff     = {{9{s_ff.k[6]}}, s_ff.k};
		res      = 8'h00;
		mask     = 8'h01 << s_ff.sel;
		ncyc     = `BSX_CYC_ONE;
		cm       = 32'h0;
		mem_used = 1'b0;
		wr_fire  = 1'b0;
		// pc is 16 bits: only byte lanes 0 and 1 of a write can land
		pw       = merge({16'h0, s_ff.pc}, s_ff.wdata, s_ff.wstrb);
		nxt_s    = s_ff;
		nxt_s.done = 1'b0;
		mem_we    = 1'b0;
		mem_addr  = s_ff.ioa;
		mem_wdata = s_ff.iowd;

		// bus handshakes
		if (s_axi_awvalid && s_ff.awready) begin
			nxt_s.aw_have = 1'b1;
			nxt_s.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_ff.wready) begin
			nxt_s.w_have = 1'b1;
			nxt_s.wdata  = s_axi_wdata;
			nxt_s.wstrb  = s_axi_wstrb;
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_ff.arready) begin
			nxt_s.ar_have = 1'b1;
			nxt_s.araddr  = s_axi_araddr;
		end

		// execution
		case (s_ff.fsm)
			bsx_pkg::ST_FIRST: begin
				nxt_s.tested = c_tested;
				nxt_s.taken  = c_true;
				nxt_s.pc     = pc1;
				case (s_ff.op)
					bsx_pkg::SHIFT_LEFT_LOGICAL: begin
						res = {s_ff.rd[6:0], 1'b0};
						nxt_s.rd = res;
						nxt_s.status_flag_register[`BSX_FLG_C] = s_ff.rd[7];
						nxt_s.status_flag_register[`BSX_FLG_N] = res[7];
						nxt_s.status_flag_register[`BSX_FLG_V] = res[7] ^ s_ff.rd[7];
						nxt_s.status_flag_register[`BSX_FLG_Z] = (res == 8'h00);
					end
					bsx_pkg::SHIFT_RIGHT_LOGICAL: begin
						res = {1'b0, s_ff.rd[7:1]};
						nxt_s.rd = res;
						nxt_s.status_flag_register[`BSX_FLG_C] = s_ff.rd[0];
						nxt_s.status_flag_register[`BSX_FLG_N] = 1'b0;
						nxt_s.status_flag_register[`BSX_FLG_V] = s_ff.rd[0];
						nxt_s.status_flag_register[`BSX_FLG_Z] = (res == 8'h00);
					end
					bsx_pkg::SET_IO_REGISTER_BIT: begin
						nxt_s.iowd = mem_rdata | mask;
						ncyc = `BSX_CYC_TWO;
					end
					bsx_pkg::CLEAR_IO_REGISTER_BIT: begin
						nxt_s.iowd = mem_rdata & ~mask;
						ncyc = `BSX_CYC_TWO;
					end
					default: begin
						if (bsx_pkg::is_skip(s_ff.op) && c_true) begin
							// skipped instruction length decides pc step and cost
							nxt_s.pc = s_ff.pc + (s_ff.two ? 16'h0003 : 16'h0002);
							ncyc = s_ff.two ? `BSX_CYC_THREE : `BSX_CYC_TWO;
						end else if (bsx_pkg::is_branch(s_ff.op) && c_true) begin
							nxt_s.pc = pc1 + koff;
							ncyc = `BSX_CYC_TWO;
						end
					end
				endcase
				nxt_s.ncyc = ncyc;
				nxt_s.cnt  = `BSX_CYC_TWO;
				if (ncyc == `BSX_CYC_ONE) begin
					nxt_s.fsm  = bsx_pkg::ST_IDLE;
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
				end else begin
					nxt_s.fsm = bsx_pkg::ST_REST;
				end
			end
			bsx_pkg::ST_REST: begin
				if (s_ff.cnt == s_ff.ncyc) begin
					// write-back only in the last cycle keeps the read-modify-write atomic
					if (bsx_pkg::is_bitop(s_ff.op)) begin
						mem_we   = 1'b1;
						mem_used = 1'b1;
					end
					nxt_s.fsm  = bsx_pkg::ST_IDLE;
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
				end else begin
					nxt_s.cnt = s_ff.cnt + 2'h1;
				end
			end
			default: begin
			end
		endcase

		// register writes; io writes wait while an operation runs
		wr_fire = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid &&
			!(is_io(s_ff.awaddr) && s_ff.fsm != bsx_pkg::ST_IDLE);
		if (wr_fire) begin
			nxt_s.aw_have = 1'b0;
			nxt_s.w_have  = 1'b0;
			nxt_s.bvalid  = 1'b1;
			nxt_s.bresp   = `BSX_RESP_OKAY;
			cm = merge(cmd_view(s_ff), s_ff.wdata, s_ff.wstrb);
			if (is_io(s_ff.awaddr)) begin
				mem_used = 1'b1;
				if (s_ff.wstrb[0]) begin
					mem_we    = 1'b1;
					mem_addr  = s_ff.awaddr[7:2];
					mem_wdata = s_ff.wdata[7:0];
				end
			end else if (s_ff.fsm == bsx_pkg::ST_IDLE) begin
				case (s_ff.awaddr)
					`BSX_OFS_CMD: begin
						nxt_s.op    = bsx_pkg::bsx_op_t'(cm[`BSX_CMD_OP]);
						nxt_s.sel   = cm[`BSX_CMD_SEL];
						nxt_s.ioa   = cm[`BSX_CMD_IOA];
						nxt_s.two   = cm[`BSX_CMD_TWO];
						nxt_s.k     = cm[`BSX_CMD_K];
						nxt_s.fsm   = bsx_pkg::ST_FIRST;
						nxt_s.busy  = 1'b1;
						nxt_s.start_pc   = s_ff.pc;
						nxt_s.start_status_flag_register = s_ff.status_flag_register;
						nxt_s.start_rd   = s_ff.rd;
						mem_addr = cm[`BSX_CMD_IOA];
						mem_used = 1'b1;
					end
					`BSX_OFS_PC:   nxt_s.pc   = pw[15:0];
					`BSX_OFS_STATUS_FLAG_REGISTER: nxt_s.status_flag_register = s_ff.wstrb[0] ? s_ff.wdata[7:0] : s_ff.status_flag_register;
					`BSX_OFS_RD:   nxt_s.rd   = s_ff.wstrb[0] ? s_ff.wdata[7:0] : s_ff.rd;
					`BSX_OFS_STAT: begin
					end
					default:       nxt_s.bresp = `BSX_RESP_SLVERR;
				endcase
			end else if (!(s_ff.awaddr inside {`BSX_OFS_CMD, `BSX_OFS_PC, `BSX_OFS_STATUS_FLAG_REGISTER,
				`BSX_OFS_RD, `BSX_OFS_STAT})) begin
				nxt_s.bresp = `BSX_RESP_SLVERR;
			end
		end

		// register reads; io reads take one extra cycle through the memory
		if (s_ff.ar_wait) begin
			nxt_s.ar_wait = 1'b0;
			nxt_s.rvalid  = 1'b1;
			nxt_s.rresp   = `BSX_RESP_OKAY;
			nxt_s.rdata   = {24'h0, mem_rdata};
		end else if (s_ff.ar_have && !s_ff.rvalid) begin
			if (is_io(s_ff.araddr)) begin
				if (s_ff.fsm == bsx_pkg::ST_IDLE && !mem_used) begin
					mem_addr      = s_ff.araddr[7:2];
					nxt_s.ar_have = 1'b0;
					nxt_s.ar_wait = 1'b1;
				end
			end else begin
				nxt_s.ar_have = 1'b0;
				nxt_s.rvalid  = 1'b1;
				nxt_s.rresp   = `BSX_RESP_OKAY;
				case (s_ff.araddr)
					`BSX_OFS_CMD:  nxt_s.rdata = cmd_view(s_ff);
					`BSX_OFS_PC:   nxt_s.rdata = {16'h0, s_ff.pc};
					`BSX_OFS_STATUS_FLAG_REGISTER: nxt_s.rdata = {24'h0, s_ff.status_flag_register};
					`BSX_OFS_RD:   nxt_s.rdata = {24'h0, s_ff.rd};
					`BSX_OFS_STAT: nxt_s.rdata = {26'h0, s_ff.ncyc, 1'b0,
						s_ff.tested, s_ff.taken, s_ff.busy};
					default: begin
						nxt_s.rdata = 32'h0;
						nxt_s.rresp = `BSX_RESP_SLVERR;
					end
				endcase
			end
		end

		nxt_s.awready = !nxt_s.aw_have && !nxt_s.bvalid;
		nxt_s.wready  = !nxt_s.w_have && !nxt_s.bvalid;
		nxt_s.arready = !nxt_s.ar_have && !nxt_s.ar_wait && !nxt_s.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff      <= '0;
			s_ff.pc   <= `BSX_PC_RST;
			s_ff.status_flag_register <= `BSX_STATUS_FLAG_REGISTER_RST;
			s_ff.rd   <= `BSX_RD_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready  = s_ff.wready;
	assign s_axi_bresp   = s_ff.bresp;
	assign s_axi_bvalid  = s_ff.bvalid;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rdata   = s_ff.rdata;
	assign s_axi_rresp   = s_ff.rresp;
	assign s_axi_rvalid  = s_ff.rvalid;
	assign exec_busy     = s_ff.busy;
	assign exec_done     = s_ff.done;

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [15:0] chk_koff;
	logic        chk_wbit;
	assign chk_koff = {{9{s_ff.k[6]}}, s_ff.k};
	assign chk_wbit = mem_wdata[s_ff.sel];

	a_skip_low_pc: assert property (s_ff.done && s_ff.op == bsx_pkg::SKIP_ON_IO_BIT_LOW |->
		s_ff.taken == !s_ff.tested && s_ff.pc == s_ff.start_pc +
		(s_ff.taken ? (s_ff.two ? 16'h0003 : 16'h0002) : 16'h0001))
		else $error("skip on low bit moved pc wrongly");
	a_skip_high_pc: assert property (s_ff.done && s_ff.op == bsx_pkg::SKIP_ON_IO_BIT_HIGH |->
		s_ff.taken == s_ff.tested && s_ff.pc == s_ff.start_pc +
		(s_ff.taken ? (s_ff.two ? 16'h0003 : 16'h0002) : 16'h0001))
		else $error("skip on high bit moved pc wrongly");
	a_skip_cost: assert property (s_ff.done && bsx_pkg::is_skip(s_ff.op) |->
		s_ff.ncyc == (!s_ff.taken ? 2'h1 : (s_ff.two ? 2'h3 : 2'h2)))
		else $error("skip cost wrong");
	a_busy_span: assert property (s_ff.done && s_ff.ncyc == 2'h2 |->
		$past(s_ff.busy, 2) && !$past(s_ff.busy, 3))
		else $error("busy span does not match cost");
	a_branch_pc: assert property (s_ff.done && bsx_pkg::is_branch(s_ff.op) |->
		s_ff.pc == s_ff.start_pc + 16'h0001 + (s_ff.taken ? chk_koff : 16'h0000)
		&& s_ff.ncyc == (s_ff.taken ? 2'h2 : 2'h1))
		else $error("branch target or cost wrong");
	a_flags_kept: assert property (s_ff.done && !(s_ff.op inside
		{bsx_pkg::SHIFT_LEFT_LOGICAL, bsx_pkg::SHIFT_RIGHT_LOGICAL}) |->
		s_ff.status_flag_register == s_ff.start_status_flag_register)
		else $error("flags changed by a non-shift operation");
	a_equal_test: assert property (s_ff.done && s_ff.op == bsx_pkg::BRANCH_ON_EQUAL |->
		s_ff.taken == s_ff.start_status_flag_register[`BSX_FLG_Z])
		else $error("equal branch decision wrong");
	a_signed_ge: assert property (s_ff.done && s_ff.op == bsx_pkg::BRANCH_SIGNED_GE |->
		s_ff.taken == !(s_ff.start_status_flag_register[`BSX_FLG_N] ^ s_ff.start_status_flag_register[`BSX_FLG_V]))
		else $error("signed ge decision wrong");
	a_bit_set: assert property (s_ff.done && s_ff.op == bsx_pkg::SET_IO_REGISTER_BIT |->
		$past(mem_we) && $past(chk_wbit) && s_ff.ncyc == 2'h2)
		else $error("io bit not set in two cycles");
	a_bit_clear: assert property (s_ff.done && s_ff.op == bsx_pkg::CLEAR_IO_REGISTER_BIT |->
		$past(mem_we) && !$past(chk_wbit) && s_ff.ncyc == 2'h2)
		else $error("io bit not cleared in two cycles");
	a_shift_left: assert property (s_ff.done && s_ff.op == bsx_pkg::SHIFT_LEFT_LOGICAL |->
		s_ff.rd == {s_ff.start_rd[6:0], 1'b0} && s_ff.status_flag_register[`BSX_FLG_C] == s_ff.start_rd[7]
		&& s_ff.status_flag_register[`BSX_FLG_Z] == (s_ff.rd == 8'h00) && s_ff.ncyc == 2'h1)
		else $error("left shift result or flags wrong");
	a_shift_right: assert property (s_ff.done && s_ff.op == bsx_pkg::SHIFT_RIGHT_LOGICAL |->
		s_ff.rd == {1'b0, s_ff.start_rd[7:1]} && s_ff.status_flag_register[`BSX_FLG_C] == s_ff.start_rd[0]
		&& !s_ff.status_flag_register[`BSX_FLG_N] && s_ff.status_flag_register[`BSX_FLG_V] == s_ff.start_rd[0])
		else $error("right shift result or flags wrong");

	c_skip_two: cover property (s_ff.done && bsx_pkg::is_skip(s_ff.op) && s_ff.taken && s_ff.two);
	c_branch_back: cover property (s_ff.done && bsx_pkg::is_branch(s_ff.op) && s_ff.taken
		&& s_ff.k[6]);
	c_bit_set: cover property (s_ff.done && s_ff.op == bsx_pkg::SET_IO_REGISTER_BIT);
	c_io_read: cover property (s_ff.rvalid && s_ff.araddr[`BSX_IOWIN_BIT]);
endmodule : bsx_exec

// *** dv/bsx_exec_test.sv ***
// bsx_exec_test: self-checking bench for the branch, skip and bit-op block.
// assumes the axi4-lite slave is the only way in; the bench acts as master.
`timescale 1ns/1ps
module bsx_exec_test;
	// ==========================================================
	// stimulus and observation
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [8:0]  awaddr = 9'h000;
	logic [8:0]  araddr = 9'h000;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, exec_busy, exec_done;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          bcnt = 0;

	bsx_exec dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .exec_busy(exec_busy), .exec_done(exec_done));

	always #5 aclk = ~aclk;

	// busy edges are counted here so the cost is seen at the port
	always @(posedge aclk) begin
		cyc++;
		if (exec_busy === 1'b1) bcnt++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("unexpected at %0t: timeout", $time);
			results();
		end
	end

	// ==========================================================
	// bus cycles and checks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [8:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	function automatic logic [31:0] mk(input logic [4:0] o, input logic [2:0] s,
		input logic [5:0] a, input logic two, input logic [6:0] k);
		return {k, two, 2'h0, a, 5'h0, s, 3'h0, o};
	endfunction : mk

	// one operation from pc 0x1000; checks pc, flags, operand and busy length
	task automatic run(input logic [31:0] cmd, input logic [7:0] sr, input logic [7:0] rv,
		input logic [15:0] epc, input logic [7:0] esr, input logic [7:0] erv, input int ec);
		logic [31:0] d;
		logic [1:0]  r;
		wr(9'h004, 32'h1000, r);
		wr(9'h008, {24'h0, sr}, r);
		wr(9'h00C, {24'h0, rv}, r);
		bcnt = 0;
		wr(9'h000, cmd, r);
		while (exec_done !== 1'b1) @(posedge aclk);
		chk(bcnt, ec);
		rd(9'h004, d, r);
		chk(d & 32'hFFFF, {16'h0, epc});
		rd(9'h008, d, r);
		chk(d & 32'hFF, {24'h0, esr});
		rd(9'h00C, d, r);
		chk(d & 32'hFF, {24'h0, erv});
	endtask : run

	// ==========================================================
	// scenarios
	task automatic branches();
		logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
		logic [6:0] k;
		logic [2:0] s;
		logic       f;
		logic       t;
		for (int o = 2; o < 22; o++) begin
			for (int j = 0; j < 4; j++) begin
				k = j[0] ? 7'h40 : 7'h3F;
				s = 3'(o + j);
				case (o)
					2, 3: f = pat[j][s];
					4, 5: f = pat[j][1];
					6, 7, 8, 9: f = pat[j][0];
					10, 11: f = pat[j][2];
					12, 13: f = pat[j][2] ^ pat[j][3];
					14, 15: f = pat[j][5];
					16, 17: f = pat[j][6];
					18, 19: f = pat[j][3];
					default: f = pat[j][7];
				endcase
				t = (o == 8 || o == 12 || (o[0] && o != 9 && o != 13)) ? !f : f;
				run(mk(5'(o), s, 6'h0, 1'b0, k), pat[j], 8'h00,
					t ? 16'h1001 + {{9{k[6]}}, k} : 16'h1001, pat[j], 8'h00, t ? 2 : 1);
			end
		end
	endtask : branches

	task automatic skips();
		logic [7:0]  v = 8'hA5;
		logic [31:0] d;
		logic [1:0]  r;
		logic        t;
		wr(9'h114, 32'hA5, r);
		for (int i = 0; i < 16; i++) begin
			t = (v[3'(i)] == i[3]);
			run(mk(5'(i[3]), 3'(i), 6'h05, i[1], 7'h7F), 8'hC3, 8'h00,
				t ? 16'h1002 + i[1] : 16'h1001, 8'hC3, 8'h00, t ? 2 + i[1] : 1);
			// status keeps cost, tested io bit and verdict of the last operation
			rd(9'h010, d, r);
			chk(d, {26'h0, t ? 2'(2 + i[1]) : 2'h1, 1'b0, v[3'(i)], t, 1'b0});
		end
	endtask : skips

	task automatic bitops();
		logic [7:0]  v = 8'h5A;
		logic [31:0] d;
		logic [1:0]  r;
		wr(9'h1FC, 32'h5A, r);
		for (int i = 0; i < 16; i++) begin
			v[3'(i * 3)] = !i[0];
			run(mk(5'(22 + i[0]), 3'(i * 3), 6'h3F, 1'b0, 7'h0), 8'h3C, 8'h00,
				16'h1001, 8'h3C, 8'h00, 2);
			rd(9'h1FC, d, r);
			chk(d, {24'h0, v});
		end
	endtask : bitops

	task automatic shifts();
		logic [7:0] pat [4] = '{8'h80, 8'h01, 8'h00, 8'h81};
		logic [7:0] res;
		logic       c;
		logic       n;
		for (int i = 0; i < 8; i++) begin
			res = i[0] ? pat[i / 2] >> 1 : pat[i / 2] << 1;
			c = i[0] ? pat[i / 2][0] : pat[i / 2][7];
			n = res[7];
			run(mk(5'(24 + i[0]), 3'h0, 6'h0, 1'b0, 7'h0), 8'hFA, pat[i / 2], 16'h1001,
				{4'hF, n ^ c, n, res == 8'h00, c}, res, 1);
		end
	endtask : shifts

	task automatic results();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(9'h004, d, r);
		chk(d, 32'h0);
		wr(9'h014, 32'h0, r);
		chk({30'h0, r}, 32'h2);
		rd(9'h014, d, r);
		chk({30'h0, r}, 32'h2);
		branches();
		skips();
		bitops();
		shifts();
		// an unused operation code must only step pc, in one cycle
		run(mk(5'h1A, 3'h0, 6'h00, 1'b0, 7'h40), 8'h5A, 8'h33, 16'h1001, 8'h5A, 8'h33, 1);
		results();
	end
endmodule : bsx_exec_test
